// ===== pkg/pwp_map.svh
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PWP_IDX_ENABLE   8'h40
`define PWP_IDX_POLCLK   8'h41
`define PWP_IDX_SCALE_A  8'h44
`define PWP_IDX_SCNT_A   8'h45
`define PWP_IDX_SCALE_B  8'h46
`define PWP_IDX_SCNT_B   8'h47
`define PWP_IDX_COUNT0   8'h48
`define PWP_IDX_PERIOD0  8'h4c
`define PWP_IDX_DUTY0    8'h50
`define PWP_IDX_CTRL     8'h54
`define PWP_IDX_TEST     8'h55
`define PWP_IDX_DATA     8'h56
`define PWP_IDX_DIR      8'h57

// ****************************************************************
// field positions and write masks
// ****************************************************************
`define PWP_CTRL_BSTOP   0
`define PWP_CTRL_CENTER  3
`define PWP_CTRL_MASK    8'h1f
`define PWP_TEST_SCAL    5
`define PWP_TEST_PCMP    6
`define PWP_TEST_CRST    7
`define PWP_TEST_MASK    8'he0

// ****************************************************************
// reset values and full-duty code
// ****************************************************************
`define PWP_RST_ZERO     8'h00
`define PWP_RST_DUTY     8'hff
`define PWP_RST_PERIOD   8'hff
`define PWP_DUTY_FULL    8'hff

// ****************************************************************
// timing
// ****************************************************************
`define PWP_PRESC_W      7

`endif

// ===== pkg/pwp_pkg.sv
package pwp_pkg;
    typedef logic [7:0] pwp_byte_t;
    typedef enum logic {PWP_UP, PWP_DOWN} pwp_dir_e;
endpackage : pwp_pkg

// ===== hw/pwp_channel.sv
`timescale 1ns/1ps
`include "pwp_map.svh"

module pwp_channel
    import pwp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      tick,
    input  wire logic      enable,
    input  wire logic      center,
    input  wire logic      polarity,
    input  wire pwp_byte_t duty,
    input  wire pwp_byte_t period,
    input  wire logic      cnt_write,
    input  wire logic      cnt_keep,
    input  wire logic      per_cmp_off,
    output pwp_byte_t      count,
    output logic           wave
);
    pwp_byte_t cnt_q;
    pwp_byte_t duty_b_q;
    pwp_byte_t per_b_q;
    pwp_dir_e  dir_q;
    logic      wave_q;
    logic      run;
    logic      rollover;
    logic      level;

    assign run = enable & tick;
    assign rollover = run & (center ? (dir_q == PWP_DOWN && cnt_q == 8'h00)
                                    : (cnt_q == per_b_q && !per_cmp_off));

    // ****************************************************************
    // counter
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `PWP_RST_ZERO;
            dir_q <= PWP_UP;
        end else if (cnt_write) begin
            if (!cnt_keep) begin
                cnt_q <= `PWP_RST_ZERO;
                dir_q <= PWP_UP;
            end
        end else if (run) begin
            if (!center) begin
                if (cnt_q == per_b_q && !per_cmp_off) begin
                    cnt_q <= `PWP_RST_ZERO;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end else if (per_b_q == 8'h00) begin
                cnt_q <= `PWP_RST_ZERO;
            end else begin
                case (dir_q)
                    PWP_UP: begin
                        if (cnt_q >= per_b_q) begin
                            dir_q <= PWP_DOWN;
                            cnt_q <= cnt_q - 8'h01;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    PWP_DOWN: begin
                        if (cnt_q == 8'h00) begin
                            dir_q <= PWP_UP;
                            cnt_q <= 8'h01;
                        end else begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                    default: dir_q <= PWP_UP;
                endcase
            end
        end
    end

    // ****************************************************************
    // buffered duty and period
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_b_q <= `PWP_RST_DUTY;
            per_b_q  <= `PWP_RST_PERIOD;
        end else if (!enable || rollover || (cnt_write && !cnt_keep)) begin
            duty_b_q <= duty;
            per_b_q  <= period;
        end
    end

    // ****************************************************************
    // output level, active-high form before polarity
    // ****************************************************************
    always_comb begin
        level = 1'b0;
        if (!center) begin
            if (duty_b_q == `PWP_DUTY_FULL && per_b_q != 8'h00) begin
                level = 1'b0;
            end else if (duty_b_q >= per_b_q || per_b_q == 8'h00) begin
                level = 1'b1;
            end else begin
                level = (cnt_q <= duty_b_q);
            end
        end else begin
            if (per_b_q == 8'h00 || duty_b_q >= per_b_q) begin
                level = (per_b_q == 8'h00) | (duty_b_q != 8'h00);
            end else if (duty_b_q == 8'h00) begin
                level = 1'b0;
            end else begin
                level = (cnt_q < duty_b_q);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= polarity ? level : ~level;
        end
    end

    assign count = cnt_q;
    assign wave  = wave_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cnt_keep;
        cnt_write && cnt_keep |=> $stable(cnt_q);
    endproperty
    a_cnt_keep: assert property (p_cnt_keep) else $error("counter changed on kept write");

    property p_cnt_clear;
        cnt_write && !cnt_keep |=> cnt_q == 8'h00 ##1 (per_b_q == $past(period, 2));
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear");

    property p_no_period_reset;
        run && !cnt_write && !center && per_cmp_off && cnt_q == per_b_q && cnt_q != 8'hff
            |=> cnt_q == per_b_q + 8'h01;
    endproperty
    a_no_period_reset: assert property (p_no_period_reset) else $error("period match reset");

    property p_full_duty;
        !center && duty_b_q == `PWP_DUTY_FULL && per_b_q != 8'h00 |=> wave_q == !$past(polarity);
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty level wrong");

    property p_center_zero;
        center && duty_b_q == 8'h00 && per_b_q != 8'h00 |=> wave_q == !$past(polarity);
    endproperty
    a_center_zero: assert property (p_center_zero) else $error("center zero duty wrong");
endmodule : pwp_channel

// ===== hw/pwp_top.sv
`timescale 1ns/1ps
`include "pwp_map.svh"

module pwp_top
    import pwp_pkg::*;
#(
    parameter int CLKA_SHIFT = 0,
    parameter int CLKB_SHIFT = 0
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        special_mode_n,
    input  wire logic        background_mode,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe
);
    if (CLKA_SHIFT < 0 || CLKA_SHIFT > `PWP_PRESC_W) begin : g_chk_a
        $error("CLKA_SHIFT out of range");
    end
    if (CLKB_SHIFT < 0 || CLKB_SHIFT > `PWP_PRESC_W) begin : g_chk_b
        $error("CLKB_SHIFT out of range");
    end

    function automatic logic div_tick(input logic [`PWP_PRESC_W-1:0] presc, input int sh);
        logic [`PWP_PRESC_W:0] mask;
        mask = (`PWP_PRESC_W+1)'((1 << sh) - 1);
        return ({1'b0, presc} & mask) == mask;
    endfunction : div_tick

    function automatic logic idx_mapped(input pwp_byte_t idx);
        return (idx == `PWP_IDX_ENABLE) || (idx == `PWP_IDX_POLCLK) ||
               (idx >= `PWP_IDX_SCALE_A && idx <= `PWP_IDX_DIR);
    endfunction : idx_mapped

    // ****************************************************************
    // apb slave
    // ****************************************************************
    pwp_byte_t idx;
    pwp_byte_t wdat;
    logic      access;
    logic      wr_fire;
    logic      pready_q;
    logic      pslverr_q;
    logic [31:0] prdata_q;
    pwp_byte_t rd_data;

    assign idx     = paddr[9:2];
    assign wdat    = pwdata[7:0];
    assign access  = psel & penable;
    assign wr_fire = access & pready_q & pwrite & idx_mapped(idx) & (paddr[1:0] == 2'b00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access & !pready_q;
            pslverr_q <= access & !pready_q & !(idx_mapped(idx) && paddr[1:0] == 2'b00);
            prdata_q  <= (access && !pready_q && !pwrite) ? {24'h00_0000, rd_data} : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [3:0] en_q;
    pwp_byte_t  polclk_q;
    pwp_byte_t  ctrl_q;
    pwp_byte_t  test_q;
    pwp_byte_t  data_q;
    pwp_byte_t  dir_q;
    pwp_byte_t  scale_a_q;
    pwp_byte_t  scale_b_q;
    pwp_byte_t  duty_q [4];
    pwp_byte_t  per_q  [4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q      <= 4'h0;
            polclk_q  <= `PWP_RST_ZERO;
            ctrl_q    <= `PWP_RST_ZERO;
            data_q    <= `PWP_RST_ZERO;
            dir_q     <= `PWP_RST_ZERO;
            scale_a_q <= `PWP_RST_ZERO;
            scale_b_q <= `PWP_RST_ZERO;
            for (int i = 0; i < 4; i++) begin
                duty_q[i] <= `PWP_RST_DUTY;
                per_q[i]  <= `PWP_RST_PERIOD;
            end
        end else if (wr_fire) begin
            case (idx)
                `PWP_IDX_ENABLE:  en_q      <= wdat[3:0];
                `PWP_IDX_POLCLK:  polclk_q  <= wdat;
                `PWP_IDX_CTRL:    ctrl_q    <= wdat & `PWP_CTRL_MASK;
                `PWP_IDX_DATA:    data_q    <= wdat;
                `PWP_IDX_DIR:     dir_q     <= wdat;
                `PWP_IDX_SCALE_A: scale_a_q <= wdat;
                `PWP_IDX_SCALE_B: scale_b_q <= wdat;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (idx == `PWP_IDX_PERIOD0 + 8'(i)) per_q[i]  <= wdat;
                        if (idx == `PWP_IDX_DUTY0 + 8'(i))   duty_q[i] <= wdat;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_q <= `PWP_RST_ZERO;
        end else if (special_mode_n) begin
            test_q <= `PWP_RST_ZERO;
        end else if (wr_fire && idx == `PWP_IDX_TEST) begin
            test_q <= wdat & `PWP_TEST_MASK;
        end
    end

    // ****************************************************************
    // clock chain: prescaler, clocks a and b, scaled clocks
    // ****************************************************************
    logic [`PWP_PRESC_W-1:0] presc_q;
    logic       run_en;
    logic       tick_a;
    logic       tick_b;
    pwp_byte_t  scnt_a_q;
    pwp_byte_t  scnt_b_q;
    logic       half_a_q;
    logic       half_b_q;
    logic       tick_sa;
    logic       tick_sb;
    logic       scal_ld;

    assign run_en  = !(ctrl_q[`PWP_CTRL_BSTOP] && background_mode);
    assign tick_a  = run_en & div_tick(presc_q, CLKA_SHIFT);
    assign tick_b  = run_en & div_tick(presc_q, CLKB_SHIFT);
    assign tick_sa = tick_a & (scnt_a_q == 8'h00) & half_a_q;
    assign tick_sb = tick_b & (scnt_b_q == 8'h00) & half_b_q;
    assign scal_ld = wr_fire & !test_q[`PWP_TEST_SCAL];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else if (run_en) begin
            presc_q <= presc_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scnt_a_q <= `PWP_RST_ZERO;
            half_a_q <= 1'b0;
        end else if (scal_ld && idx == `PWP_IDX_SCALE_A) begin
            scnt_a_q <= wdat;
        end else if (tick_a) begin
            scnt_a_q <= (scnt_a_q == 8'h00) ? scale_a_q : scnt_a_q - 8'h01;
            half_a_q <= half_a_q ^ (scnt_a_q == 8'h00);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scnt_b_q <= `PWP_RST_ZERO;
            half_b_q <= 1'b0;
        end else if (scal_ld && idx == `PWP_IDX_SCALE_B) begin
            scnt_b_q <= wdat;
        end else if (tick_b) begin
            scnt_b_q <= (scnt_b_q == 8'h00) ? scale_b_q : scnt_b_q - 8'h01;
            half_b_q <= half_b_q ^ (scnt_b_q == 8'h00);
        end
    end

    // ****************************************************************
    // channels
    // ****************************************************************
    pwp_byte_t  count [4];
    logic [3:0] wave;
    logic [3:0] ch_tick;

    for (genvar g = 0; g < 4; g++) begin : g_ch
        assign ch_tick[g] = (g < 2) ? (polclk_q[4+g] ? tick_sa : tick_a)
                                    : (polclk_q[4+g] ? tick_sb : tick_b);
        pwp_channel u_ch (
            .clk         (pclk),
            .rst_n       (presetn),
            .tick        (ch_tick[g]),
            .enable      (en_q[g]),
            .center      (ctrl_q[`PWP_CTRL_CENTER]),
            .polarity    (polclk_q[g]),
            .duty        (duty_q[g]),
            .period      (per_q[g]),
            .cnt_write   (wr_fire && idx == `PWP_IDX_COUNT0 + 8'(g)),
            .cnt_keep    (test_q[`PWP_TEST_CRST]),
            .per_cmp_off (test_q[`PWP_TEST_PCMP]),
            .count       (count[g]),
            .wave        (wave[g])
        );
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        rd_data = `PWP_RST_ZERO;
        case (idx)
            `PWP_IDX_ENABLE:  rd_data = {4'h0, en_q};
            `PWP_IDX_POLCLK:  rd_data = polclk_q;
            `PWP_IDX_SCALE_A: rd_data = scale_a_q;
            `PWP_IDX_SCNT_A:  rd_data = scnt_a_q;
            `PWP_IDX_SCALE_B: rd_data = scale_b_q;
            `PWP_IDX_SCNT_B:  rd_data = scnt_b_q;
            `PWP_IDX_CTRL:    rd_data = ctrl_q;
            `PWP_IDX_TEST:    rd_data = test_q;
            `PWP_IDX_DIR:     rd_data = dir_q;
            `PWP_IDX_DATA: begin
                for (int i = 0; i < 8; i++) begin
                    if (dir_q[i]) rd_data[i] = data_q[i];
                end
                for (int i = 0; i < 4; i++) begin
                    if (!dir_q[i]) rd_data[i] = pin_in[i];
                end
            end
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (idx == `PWP_IDX_COUNT0 + 8'(i))  rd_data = count[i];
                    if (idx == `PWP_IDX_PERIOD0 + 8'(i)) rd_data = per_q[i];
                    if (idx == `PWP_IDX_DUTY0 + 8'(i))   rd_data = duty_q[i];
                end
            end
        endcase
    end

    // ****************************************************************
    // pins
    // ****************************************************************
    logic [3:0] pin_out_q;
    logic [3:0] pin_oe_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= 4'h0;
            pin_oe_q  <= 4'h0;
        end else begin
            pin_out_q <= (en_q & wave) | (~en_q & data_q[3:0]);
            pin_oe_q  <= en_q | dir_q[3:0];
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe  = pin_oe_q;
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_test_normal;
        special_mode_n |=> test_q == 8'h00;
    endproperty
    a_test_normal: assert property (p_test_normal) else $error("test bits set in normal mode");

    property p_test_special;
        wr_fire && idx == `PWP_IDX_TEST && !special_mode_n |=> test_q == ($past(wdat) & 8'he0);
    endproperty
    a_test_special: assert property (p_test_special) else $error("test write lost");

    property p_bstop;
        ctrl_q[`PWP_CTRL_BSTOP] && background_mode |=> $stable(presc_q);
    endproperty
    a_bstop: assert property (p_bstop) else $error("pwm clock ran in background");

    property p_scal_block;
        wr_fire && idx == `PWP_IDX_SCALE_A && test_q[`PWP_TEST_SCAL] && !tick_a
            |=> $stable(scnt_a_q);
    endproperty
    a_scal_block: assert property (p_scal_block) else $error("scale counter reloaded");

    property p_pin_pwm;
        en_q[0] |=> pin_oe[0] && pin_out[0] == $past(wave[0]);
    endproperty
    a_pin_pwm: assert property (p_pin_pwm) else $error("pwm not on pin");

    property p_pin_gpio;
        !en_q[1] && dir_q[1] |=> pin_oe[1] && pin_out[1] == $past(data_q[1]);
    endproperty
    a_pin_gpio: assert property (p_pin_gpio) else $error("port data not driven");

    property p_pin_hiz;
        !en_q[2] && !dir_q[2] |=> !pin_oe[2];
    endproperty
    a_pin_hiz: assert property (p_pin_hiz) else $error("input pin driven");

    property p_rd_nopin;
        access && !pready_q && !pwrite && idx == `PWP_IDX_DATA && paddr[1:0] == 2'b00
            && !dir_q[7] |=> pready && prdata[7] == 1'b0;
    endproperty
    a_rd_nopin: assert property (p_rd_nopin) else $error("pinless input bit read high");

    property p_rd_latched;
        access && !pready_q && !pwrite && idx == `PWP_IDX_DATA && paddr[1:0] == 2'b00
            && dir_q[5] |=> prdata[5] == $past(data_q[5]);
    endproperty
    a_rd_latched: assert property (p_rd_latched) else $error("latched data not read");
endmodule : pwp_top

// ===== dv/pwp_pin_model.sv
`timescale 1ns/1ps

// ****************************************************************
// external pins: driven level when block drives, else far driver
// ****************************************************************
module pwp_pin_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] ext_val,
    output logic      [3:0] pin_in
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
        end
    end
endmodule : pwp_pin_model

// ===== dv/pwm_mode_port_p_control_bench.sv
`timescale 1ns/1ps
`include "pwp_map.svh"

module pwm_mode_port_p_control_bench;
    logic        pclk, presetn, psel, penable, pwrite, smode_n, bgnd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er;
    logic [3:0]  pin_in, pin_out, pin_oe, ext_val;
    int          num_errors, comparisons, cycles;

    pwp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .special_mode_n(smode_n),
        .background_mode(bgnd), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pwp_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .pin_in(pin_in));

    // ****************************************************************
    // clock, timeout, helpers
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        check({28'h0, pin_oe}, 32'h0);
        apb(1'b0, `PWP_IDX_TEST, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, `PWP_IDX_DIR, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, 8'h60, 8'h00);
        check({31'h0, er}, 32'h1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_test_reg();
        apb(1'b1, `PWP_IDX_TEST, 8'hff);
        apb(1'b0, `PWP_IDX_TEST, 8'h00);
        check(rd, 32'h0);
        smode_n <= 1'b0;
        apb(1'b1, `PWP_IDX_TEST, 8'hff);
        apb(1'b0, `PWP_IDX_TEST, 8'h00);
        check(rd, 32'he0);
        smode_n <= 1'b1;
        apb(1'b0, `PWP_IDX_TEST, 8'h00);
        check(rd, 32'h0);
        $display("test register done");
    endtask : t_test_reg

    task automatic t_port();
        ext_val <= 4'ha;
        apb(1'b1, `PWP_IDX_DATA, 8'hf5);
        apb(1'b0, `PWP_IDX_DATA, 8'h00);
        check(rd, 32'h0a);
        check({28'h0, pin_oe}, 32'h0);
        apb(1'b1, `PWP_IDX_DIR, 8'ha5);
        apb(1'b0, `PWP_IDX_DIR, 8'h00);
        check(rd, 32'ha5);
        apb(1'b0, `PWP_IDX_DATA, 8'h00);
        check(rd, 32'hf5 & 32'ha5 | 32'h0a & 32'h5a);
        check({24'h0, pin_oe, pin_out}, 32'h55);
        apb(1'b1, `PWP_IDX_DIR, 8'h0f);
        apb(1'b1, `PWP_IDX_DATA, 8'h3c);
        apb(1'b0, `PWP_IDX_DATA, 8'h00);
        check(rd, 32'h0c);
        check({24'h0, pin_oe, pin_out}, 32'hfc);
        $display("port test done");
    endtask : t_port

    task automatic t_bound(input logic ctr, input logic pol, input logic [7:0] duty,
                           input logic [7:0] per, input logic lvl);
        apb(1'b1, `PWP_IDX_ENABLE, 8'h00);
        apb(1'b1, `PWP_IDX_CTRL, {4'h0, ctr, 3'h0});
        apb(1'b1, `PWP_IDX_POLCLK, {7'h0, pol});
        apb(1'b1, `PWP_IDX_PERIOD0, per);
        apb(1'b1, `PWP_IDX_DUTY0, duty);
        apb(1'b1, `PWP_IDX_COUNT0, 8'h00);
        apb(1'b1, `PWP_IDX_ENABLE, 8'h01);
        apb(1'b1, `PWP_IDX_DATA, {7'h0, ~lvl});
        repeat (40) @(posedge pclk);
        check({30'h0, pin_oe[0], pin_out[0]}, {30'h0, 1'b1, lvl});
        $display("boundary case done");
    endtask : t_bound

    task automatic t_special();
        logic [31:0] v;
        smode_n <= 1'b0;
        apb(1'b1, `PWP_IDX_ENABLE, 8'h00);
        apb(1'b1, `PWP_IDX_CTRL, 8'h01);
        apb(1'b1, `PWP_IDX_PERIOD0, 8'hf0);
        apb(1'b1, `PWP_IDX_COUNT0, 8'h00);
        apb(1'b1, `PWP_IDX_ENABLE, 8'h01);
        repeat (20) @(posedge pclk);
        bgnd <= 1'b1;
        apb(1'b0, `PWP_IDX_COUNT0, 8'h00);
        v = rd;
        repeat (8) @(posedge pclk);
        apb(1'b0, `PWP_IDX_COUNT0, 8'h00);
        check(rd, v);
        check({31'h0, v != 32'h0}, 32'h1);
        apb(1'b1, `PWP_IDX_COUNT0, 8'h5a);
        apb(1'b0, `PWP_IDX_COUNT0, 8'h00);
        check(rd, 32'h0);
        bgnd <= 1'b0;
        apb(1'b1, `PWP_IDX_TEST, 8'h80);
        bgnd <= 1'b1;
        apb(1'b0, `PWP_IDX_COUNT0, 8'h00);
        v = rd;
        apb(1'b1, `PWP_IDX_COUNT0, 8'h00);
        apb(1'b0, `PWP_IDX_COUNT0, 8'h00);
        check(rd, v);
        check({31'h0, v != 32'h0}, 32'h1);
        apb(1'b1, `PWP_IDX_TEST, 8'h20);
        apb(1'b1, `PWP_IDX_SCALE_A, 8'h33);
        apb(1'b0, `PWP_IDX_SCNT_A, 8'h00);
        check(rd, 32'h0);
        apb(1'b1, `PWP_IDX_TEST, 8'h00);
        apb(1'b1, `PWP_IDX_SCALE_A, 8'h33);
        apb(1'b0, `PWP_IDX_SCNT_A, 8'h00);
        check(rd, 32'h33);
        apb(1'b1, `PWP_IDX_TEST, 8'h40);
        apb(1'b1, `PWP_IDX_PERIOD0, 8'h04);
        apb(1'b1, `PWP_IDX_COUNT0, 8'h00);
        bgnd <= 1'b0;
        repeat (20) @(posedge pclk);
        bgnd <= 1'b1;
        apb(1'b0, `PWP_IDX_COUNT0, 8'h00);
        check({31'h0, rd > 32'h04}, 32'h1);
        apb(1'b1, `PWP_IDX_TEST, 8'h00);
        smode_n <= 1'b1;
        bgnd <= 1'b0;
        $display("special mode test done");
    endtask : t_special

    task automatic t_period(input logic ctr, input logic [7:0] per, input int want);
        int n;
        apb(1'b1, `PWP_IDX_ENABLE, 8'h00);
        apb(1'b1, `PWP_IDX_CTRL, {4'h0, ctr, 3'h0});
        apb(1'b1, `PWP_IDX_POLCLK, 8'h01);
        apb(1'b1, `PWP_IDX_PERIOD0, per);
        apb(1'b1, `PWP_IDX_DUTY0, 8'h02);
        apb(1'b1, `PWP_IDX_COUNT0, 8'h00);
        apb(1'b1, `PWP_IDX_ENABLE, 8'h01);
        while (pin_out[0] !== 1'b0) @(posedge pclk);
        while (pin_out[0] !== 1'b1) @(posedge pclk);
        n = 0;
        while (pin_out[0] !== 1'b0) begin
            n++;
            @(posedge pclk);
        end
        while (pin_out[0] !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        check(n, want);
        $display("period test done");
    endtask : t_period

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        smode_n = 1'b1;
        bgnd = 1'b0;
        ext_val = 4'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_test_reg();
        t_port();
        t_bound(1'b0, 1'b1, 8'hff, 8'h10, 1'b0);
        t_bound(1'b0, 1'b0, 8'hff, 8'h10, 1'b1);
        t_bound(1'b0, 1'b1, 8'h20, 8'h10, 1'b1);
        t_bound(1'b0, 1'b0, 8'h05, 8'h00, 1'b0);
        t_bound(1'b1, 1'b1, 8'h00, 8'h10, 1'b0);
        t_bound(1'b1, 1'b0, 8'h00, 8'h10, 1'b1);
        t_bound(1'b1, 1'b1, 8'h10, 8'h10, 1'b1);
        t_bound(1'b1, 1'b0, 8'h07, 8'h00, 1'b0);
        t_special();
        t_period(1'b0, 8'h04, 5);
        t_period(1'b1, 8'h04, 8);
        final_report();
    end
endmodule : pwm_mode_port_p_control_bench
